/* File: tcs_regs.svh */
// register layout and reset constants for the four-channel timer control/status block
// assumes: included by bare name from the block's design files; definitions only
//
// How it works
// RULE_01: flag bits accept only zero writes
// RULE_02: reset loads ch2 with 10, others zero
// RULE_03: clear needs read-as-one then zero write
// RULE_04: B match sets B flag in compare mode
// RULE_05: capture copies counter, sets B flag
// RULE_06: capture enable suppresses partner B flag
// RULE_07: A match always sets A flag
// RULE_08: counter wrap to zero sets overflow
// RULE_09: gate low blocks all converter starts
// RULE_10: gate high, enable low: pin starts
// RULE_11: gate high, enable high: compare A starts
// RULE_12: converter gate arrives as input signal
// RULE_13: ch2 bit4 read/write, resets to one
// RULE_14: capture enable picks compare or capture
// RULE_15: partner A still matches, outputs, interrupts
// RULE_16: partner B match: no output, interrupt
// RULE_17: capture channel A matches; pin input only
// RULE_18: capture sets B flag and interrupt
// RULE_19: channels 2/3 mirror channels 0/1
// RULE_20: bits 3..0 read/write, reset zero
// RULE_21: select codes keep/zero/one/toggle; all-zero disables
// RULE_22: interrupt needs flag and enable
// RULE_23: set beats clear in same cycle
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH

// ***************************************************************
// register indices (one byte register per channel)
// ***************************************************************
`define TCS_IDX_CH0        2'h0
`define TCS_IDX_CH1        2'h1
`define TCS_IDX_CH2        2'h2
`define TCS_IDX_CH3        2'h3

// ***************************************************************
// field positions
// ***************************************************************
`define TCS_FLAG_B_BIT     7
`define TCS_FLAG_A_BIT     6
`define TCS_FLAG_OVF_BIT   5
`define TCS_MODE_BIT       4
`define TCS_SEL_B_HI       3
`define TCS_SEL_B_LO       2
`define TCS_SEL_A_HI       1
`define TCS_SEL_A_LO       0

// ***************************************************************
// reset values and counter limits
// ***************************************************************
`define TCS_CSR_RST_CH0    8'h00
`define TCS_CSR_RST_CH1    8'h00
`define TCS_CSR_RST_CH2    8'h10
`define TCS_CSR_RST_CH3    8'h00
`define TCS_COUNT_MAX      8'hFF

`endif

/* File: tcs_pkg.sv */
// types shared by the timer control/status block
// assumes: compiled before any module of the block
`default_nettype none
package tcs_pkg;
   // compare-match output action, numerically ordered by priority
   typedef enum logic [1:0] {
      TCS_OUT_KEEP   = 2'h0,
      TCS_OUT_ZERO   = 2'h1,
      TCS_OUT_ONE    = 2'h2,
      TCS_OUT_TOGGLE = 2'h3
   } tcs_out_sel_t;

   // capture edge choice when register b captures
   typedef enum logic [1:0] {
      TCS_EDGE_RISE = 2'h0,
      TCS_EDGE_FALL = 2'h1,
      TCS_EDGE_BOTH = 2'h2,
      TCS_EDGE_NONE = 2'h3
   } tcs_edge_t;
endpackage : tcs_pkg
`default_nettype wire

/* File: tcs_flag.sv */
// one status flag with read-then-write-zero clearing
// assumes: read and write strobes are one-cycle pulses from the register port
`timescale 1ns/1ps
`default_nettype none
module tcs_flag (
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   input  wire logic i_set,     // hardware event
   input  wire logic i_read,    // register read strobe
   input  wire logic i_write,   // register write strobe
   input  wire logic i_wbit,    // written value of this bit
   output logic      o_flag
);
   logic armed;                 // flag was read as one since last write

   // clear only after a read that saw one, then a zero write [RULE_03]
   wire do_clear = i_write & ~i_wbit & armed;                 // [RULE_01]

   // ***************************************************************
   // flag and arm state
   // ***************************************************************
   // set dominates so no event is lost [RULE_23]
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_flag <= 1'b0;
         armed  <= 1'b0;
      end else begin
         o_flag <= i_set | (o_flag & ~do_clear);
         // any write consumes the arm; a read while set re-arms
         armed  <= i_write ? 1'b0 : (armed | (i_read & o_flag));
      end
   end
endmodule : tcs_flag
`default_nettype wire

/* File: tcs_pin.sv */
// compare-match driven timer output level for one channel
// assumes: match inputs are one-cycle pulses, already gated by the caller
`timescale 1ns/1ps
`default_nettype none
module tcs_pin (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_b,
   input  wire logic                  i_match_a,
   input  wire logic                  i_match_b,
   input  wire tcs_pkg::tcs_out_sel_t i_sel_a,
   input  wire tcs_pkg::tcs_out_sel_t i_sel_b,
   output logic                       o_level
);
   // simultaneous matches: the larger code wins (toggle > one > zero) [RULE_21]
   wire tcs_pkg::tcs_out_sel_t act_a = i_match_a ? i_sel_a : tcs_pkg::TCS_OUT_KEEP;
   wire tcs_pkg::tcs_out_sel_t act_b = i_match_b ? i_sel_b : tcs_pkg::TCS_OUT_KEEP;
   wire tcs_pkg::tcs_out_sel_t act   = (act_a > act_b) ? act_a : act_b;
   logic next_level;

   always_comb begin
      unique case (act)
         tcs_pkg::TCS_OUT_KEEP:   next_level = o_level;
         tcs_pkg::TCS_OUT_ZERO:   next_level = 1'b0;
         tcs_pkg::TCS_OUT_ONE:    next_level = 1'b1;
         tcs_pkg::TCS_OUT_TOGGLE: next_level = ~o_level;
      endcase
   end

   // output level register
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_level <= 1'b0;
      end else begin
         o_level <= next_level;
      end
   end
endmodule : tcs_pin
`default_nettype wire

/* File: tcs_ctrl.sv */
// control/status logic of four 8-bit timer channels in two pairs (0/1, 2/3)
// assumes: counter, compare registers, clock select and irq enables live outside;
// i_count_tick marks the cycle in which a channel's counter is about to update;
// i_rst_b is asserted by device reset and by standby entry alike
`include "tcs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tcs_ctrl #(
   parameter int NCH = 4        // channels; pairing logic assumes four
) (
   input  wire logic                i_clk,
   input  wire logic                i_rst_b,
   // register port
   input  wire logic [1:0]          i_addr,
   input  wire logic                i_rd,
   input  wire logic                i_wr,
   input  wire logic [7:0]          i_wdata,
   output logic      [7:0]          o_rdata,
   // counter side
   input  wire logic [NCH-1:0]      i_count_tick,
   input  wire logic [NCH-1:0][7:0] i_counter8,
   input  wire logic [NCH-1:0][7:0] i_compare_reg_a,
   input  wire logic [NCH-1:0][7:0] i_compare_reg_b,
   // interrupt enables from the channel control registers
   input  wire logic [NCH-1:0]      i_compare_a_irq_en,
   input  wire logic [NCH-1:0]      i_compare_b_irq_en,
   input  wire logic [NCH-1:0]      i_overflow_irq_en,
   // capture pins of channels 1 and 3 (index 0 = ch1, 1 = ch3)
   input  wire logic [1:0]          i_timer_io_pin,
   // converter interface
   input  wire logic                i_converter_trigger_gate,
   input  wire logic                i_converter_ext_trigger_pin,
   output logic                     o_converter_start,
   // capture results toward register b of ch1/ch3
   output logic [1:0]               o_capture_strobe,
   output logic [1:0][7:0]          o_capture_value,
   // timer outputs
   output logic [NCH-1:0]           o_timer_out_pin,
   output logic [NCH-1:0]           o_timer_out_en,
   // interrupt requests
   output logic [NCH-1:0]           o_compare_a_irq,
   output logic [NCH-1:0]           o_compare_b_irq,
   output logic [NCH-1:0]           o_overflow_irq
);
   // ***************************************************************
   // helpers
   // ***************************************************************
   // edge detect against the selected capture edge
   function automatic logic edge_hit(input logic cur, input logic prev,
                                     input tcs_pkg::tcs_edge_t sel);
      logic rise;
      logic fall;
      rise = cur & ~prev;
      fall = ~cur & prev;
      unique case (sel)
         tcs_pkg::TCS_EDGE_RISE: edge_hit = rise;
         tcs_pkg::TCS_EDGE_FALL: edge_hit = fall;
         tcs_pkg::TCS_EDGE_BOTH: edge_hit = rise | fall;
         tcs_pkg::TCS_EDGE_NONE: edge_hit = 1'b0;
      endcase
   endfunction : edge_hit

   // per-channel reset value of the control fields
   function automatic logic [7:0] csr_reset(input int ch);
      unique case (ch)
         0:       csr_reset = `TCS_CSR_RST_CH0;
         1:       csr_reset = `TCS_CSR_RST_CH1;
         2:       csr_reset = `TCS_CSR_RST_CH2;   // bit 4 comes up set [RULE_13]
         default: csr_reset = `TCS_CSR_RST_CH3;
      endcase
   endfunction : csr_reset

   // ***************************************************************
   // storage
   // ***************************************************************
   logic [NCH-1:0][4:0] ctrl_bits;      // bit 4 and select fields 3..0
   logic [NCH-1:0]      compare_b_flag; // flag bit 7
   logic [NCH-1:0]      compare_a_flag; // flag bit 6
   logic [NCH-1:0]      overflow_flag;  // flag bit 5
   logic [1:0]          pin_prev;       // last sample of capture pins

   // ***************************************************************
   // register decode
   // ***************************************************************
   logic [NCH-1:0] sel_ch;              // one-hot channel select
   logic [NCH-1:0] wr_ch;               // write strobe per channel
   logic [NCH-1:0] rd_ch;               // read strobe per channel
   logic [7:0]     rd_mux;              // read value before the output flop

   always_comb begin
      sel_ch = '0;
      sel_ch[i_addr] = 1'b1;
   end
   assign wr_ch = sel_ch & {NCH{i_wr}};
   assign rd_ch = sel_ch & {NCH{i_rd}};

   // read value: flags over the control fields
   assign rd_mux = {compare_b_flag[i_addr], compare_a_flag[i_addr],
                    overflow_flag[i_addr], ctrl_bits[i_addr]};

   // ***************************************************************
   // field views
   // ***************************************************************
   logic [1:0] capture_enable;          // pair 0 = ch1 bit 4, pair 1 = ch3 bit 4
   logic       converter_trigger_enable;

   // capture enable selects the role of register b [RULE_14]
   assign capture_enable[0]        = ctrl_bits[`TCS_IDX_CH1][`TCS_MODE_BIT];
   assign capture_enable[1]        = ctrl_bits[`TCS_IDX_CH3][`TCS_MODE_BIT];
   assign converter_trigger_enable = ctrl_bits[`TCS_IDX_CH0][`TCS_MODE_BIT];  // [RULE_09]

   // ***************************************************************
   // match, overflow and capture events
   // ***************************************************************
   logic [NCH-1:0] match_a;             // counter equals register a at update
   logic [NCH-1:0] match_b_raw;         // counter equals register b at update
   logic [NCH-1:0] match_b;             // register b match allowed to act
   logic [NCH-1:0] wrap;                // counter rolls over to zero
   logic [NCH-1:0] pair_cap;            // capture enable of each channel's pair
   logic [NCH-1:0] is_cap_ch;           // channel is the capturing one of its pair
   logic [1:0]     capture_hit;         // capture edge seen this cycle

   // matches count only when the matched value is being left, as the counter steps
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_evt
         assign pair_cap[g]    = capture_enable[g/2];
         assign is_cap_ch[g]   = (g % 2) == 1;
         assign match_a[g]     = i_count_tick[g] & (i_counter8[g] == i_compare_reg_a[g]);  // [RULE_07]
         assign match_b_raw[g] = i_count_tick[g] & (i_counter8[g] == i_compare_reg_b[g]);
         // b match acts only while b is a compare register and pair is not capturing
         assign match_b[g]     = match_b_raw[g] & ~pair_cap[g];             // [RULE_04] [RULE_06] [RULE_19]
         assign wrap[g]        = i_count_tick[g] & (i_counter8[g] == `TCS_COUNT_MAX);  // [RULE_08]
      end
   endgenerate

   // capture edge per pair, edge chosen by bits 3..2 of the capturing channel
   assign capture_hit[0] = capture_enable[0] &
      edge_hit(i_timer_io_pin[0], pin_prev[0],
               tcs_pkg::tcs_edge_t'(ctrl_bits[`TCS_IDX_CH1][`TCS_SEL_B_HI:`TCS_SEL_B_LO]));
   assign capture_hit[1] = capture_enable[1] &
      edge_hit(i_timer_io_pin[1], pin_prev[1],
               tcs_pkg::tcs_edge_t'(ctrl_bits[`TCS_IDX_CH3][`TCS_SEL_B_HI:`TCS_SEL_B_LO]));

   // b flag set sources: compare match, or capture on the capturing channel
   logic [NCH-1:0] set_b;
   assign set_b = match_b | {capture_hit[1], 1'b0, capture_hit[0], 1'b0};  // [RULE_05] [RULE_18]

   // ***************************************************************
   // status flags
   // ***************************************************************
   generate
      for (g = 0; g < NCH; g++) begin : g_flag
         tcs_flag u_flag_b (
            .i_clk   (i_clk),
            .i_rst_b (i_rst_b),
            .i_set   (set_b[g]),
            .i_read  (rd_ch[g]),
            .i_write (wr_ch[g]),
            .i_wbit  (i_wdata[`TCS_FLAG_B_BIT]),
            .o_flag  (compare_b_flag[g])
         );
         tcs_flag u_flag_a (
            .i_clk   (i_clk),
            .i_rst_b (i_rst_b),
            .i_set   (match_a[g]),                                          // [RULE_15] [RULE_17]
            .i_read  (rd_ch[g]),
            .i_write (wr_ch[g]),
            .i_wbit  (i_wdata[`TCS_FLAG_A_BIT]),
            .o_flag  (compare_a_flag[g])
         );
         tcs_flag u_flag_ovf (
            .i_clk   (i_clk),
            .i_rst_b (i_rst_b),
            .i_set   (wrap[g]),
            .i_read  (rd_ch[g]),
            .i_write (wr_ch[g]),
            .i_wbit  (i_wdata[`TCS_FLAG_OVF_BIT]),
            .o_flag  (overflow_flag[g])
         );
      end
   endgenerate

   // ***************************************************************
   // control fields
   // ***************************************************************
   // bit 4 and bits 3..0 are plain read/write; writes leave flag bits to the flag cells
   generate
      for (g = 0; g < NCH; g++) begin : g_ctrl
         always_ff @(posedge i_clk) begin
            if (!i_rst_b) begin
               ctrl_bits[g] <= 5'(csr_reset(g));                            // [RULE_02] [RULE_20]
            end else if (wr_ch[g]) begin
               ctrl_bits[g] <= i_wdata[4:0];                                // [RULE_13] [RULE_20]
            end
         end
      end
   endgenerate

   // ***************************************************************
   // read data, capture pin history and capture results
   // ***************************************************************
   // read data held until the next read; one cycle after the strobe
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         o_rdata <= rd_mux;
      end
   end

   // pins are already synchronous; one stage of history feeds edge detect
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         pin_prev <= 2'h0;
      end else begin
         pin_prev <= i_timer_io_pin;
      end
   end

   // the captured counter value is handed to register b with a strobe [RULE_05]
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_capture_strobe <= 2'h0;
         o_capture_value  <= '0;
      end else begin
         o_capture_strobe <= capture_hit;
         if (capture_hit[0]) begin
            o_capture_value[0] <= i_counter8[`TCS_IDX_CH1];
         end
         if (capture_hit[1]) begin
            o_capture_value[1] <= i_counter8[`TCS_IDX_CH3];
         end
      end
   end

   // ***************************************************************
   // timer outputs
   // ***************************************************************
   // a capturing channel's pin is input only; its partner loses b-match output
   generate
      for (g = 0; g < NCH; g++) begin : g_pin
         logic pin_level;
         tcs_pin u_pin (
            .i_clk     (i_clk),
            .i_rst_b   (i_rst_b),
            .i_match_a (match_a[g]),                                        // [RULE_15]
            .i_match_b (match_b[g]),                                        // [RULE_16]
            .i_sel_a   (tcs_pkg::tcs_out_sel_t'(ctrl_bits[g][`TCS_SEL_A_HI:`TCS_SEL_A_LO])),
            .i_sel_b   (tcs_pkg::tcs_out_sel_t'(ctrl_bits[g][`TCS_SEL_B_HI:`TCS_SEL_B_LO])),
            .o_level   (pin_level)
         );
         assign o_timer_out_pin[g] = pin_level;
         // both select fields (all four bits 3..0) zero disables the output [RULE_21]
         assign o_timer_out_en[g]  = (ctrl_bits[g][3:0] != 4'h0) &
                                     ~(pair_cap[g] & is_cap_ch[g]);          // [RULE_17] [RULE_19]
      end
   endgenerate

   // ***************************************************************
   // interrupts and converter start
   // ***************************************************************
   // requests follow the flags, gated by the enables [RULE_22]
   assign o_compare_a_irq = compare_a_flag & i_compare_a_irq_en;
   assign o_compare_b_irq = compare_b_flag & i_compare_b_irq_en;          // [RULE_16] [RULE_18]
   assign o_overflow_irq  = overflow_flag  & i_overflow_irq_en;

   // gate low blocks both sources; enable chooses compare a of ch0 or the pin
   assign o_converter_start = i_converter_trigger_gate &                  // [RULE_09] [RULE_12]
                              (converter_trigger_enable ? match_a[`TCS_IDX_CH0]  // [RULE_11]
                                                        : i_converter_ext_trigger_pin);  // [RULE_10]
endmodule : tcs_ctrl
`default_nettype wire

/* File: tcs_ctrl_sva.sv */
// concurrent checks on the ports of the timer control/status block
// assumes: one clock domain, synchronous active-low reset; bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module tcs_ctrl_sva #(
   parameter int NCH = 4         // channel count, handed on by the bind
) (
   input  wire logic                i_clk,
   input  wire logic                i_rst_b,
   input  wire logic                i_wr,
   input  wire logic [NCH-1:0]      i_count_tick,
   input  wire logic [NCH-1:0][7:0] i_counter8,
   input  wire logic [NCH-1:0][7:0] i_compare_reg_a,
   input  wire logic [NCH-1:0]      i_compare_a_irq_en,
   input  wire logic [NCH-1:0]      i_compare_b_irq_en,
   input  wire logic [NCH-1:0]      i_overflow_irq_en,
   input  wire logic                i_converter_trigger_gate,
   input  wire logic                o_converter_start,
   input  wire logic [1:0]          o_capture_strobe,
   input  wire logic [1:0][7:0]     o_capture_value,
   input  wire logic [NCH-1:0]      o_compare_a_irq,
   input  wire logic [NCH-1:0]      o_compare_b_irq,
   input  wire logic [NCH-1:0]      o_overflow_irq,
   input  wire logic [7:0]          o_rdata
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // ***************************************************************
   // event sequences
   // ***************************************************************
   // counter of channel 0 steps off its compare a value
   sequence match_a0;
      i_count_tick[0] && (i_counter8[0] == i_compare_reg_a[0]);
   endsequence
   // counter of channel 2 steps from its top value
   sequence wrap2;
      i_count_tick[2] && (i_counter8[2] == 8'hFF);
   endsequence
   // ***************************************************************
   // assertions
   // ***************************************************************
   flag_a_set_a: assert property (match_a0 ##1 i_compare_a_irq_en[0] |-> o_compare_a_irq[0])
      else $error("compare a match did not raise flag");
   ovf_set_a: assert property (wrap2 ##1 i_overflow_irq_en[2] |-> o_overflow_irq[2])
      else $error("counter wrap did not raise overflow");
   irq_gate_a: assert property ((o_compare_a_irq & ~i_compare_a_irq_en) == '0
      && (o_compare_b_irq & ~i_compare_b_irq_en) == '0 && (o_overflow_irq & ~i_overflow_irq_en) == '0)
      else $error("interrupt request without its enable");
   flag_hold_a: assert property (o_compare_a_irq[0] && !i_wr ##1 i_compare_a_irq_en[0] |-> o_compare_a_irq[0])
      else $error("flag dropped without a write");
   conv_gate_a: assert property (!i_converter_trigger_gate |-> !o_converter_start)
      else $error("converter start while gate is low");
   cap_value_a: assert property (o_capture_strobe[0] |-> o_capture_value[0] == $past(i_counter8[1]))
      else $error("captured value is not the counter");
   cap_flag_a: assert property (o_capture_strobe[0] && i_compare_b_irq_en[1] |-> ##[0:1] o_compare_b_irq[1])
      else $error("capture did not raise b flag");
   rst_clear_a: assert property (disable iff (1'b0) !i_rst_b |=> o_rdata == 8'h00 && o_compare_a_irq == '0)
      else $error("reset left state behind");
endmodule : tcs_ctrl_sva
`default_nettype wire

/* File: tcs_cpu_model.sv */
// software side of the register port: single byte reads and writes
// assumes: tasks are entered 1 ns after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module tcs_cpu_model (
   input  wire logic  i_clk,
   output logic [1:0] o_addr,
   output logic       o_rd,
   output logic       o_wr,
   output logic [7:0] o_wdata
);
   // idle bus at time zero
   initial begin
      o_addr  = 2'h0;
      o_rd    = 1'b0;
      o_wr    = 1'b0;
      o_wdata = 8'h00;
   end
   // one strobe cycle, then an idle cycle so strobes never abut
   task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d);
      o_addr  = a;
      o_wdata = d;
      o_rd    = !w;
      o_wr    = w;
      @(posedge i_clk);
      #1;
      o_rd    = 1'b0;
      o_wr    = 1'b0;
      o_wdata = ~d;   // stale data is not left looking valid
      @(posedge i_clk);
      #1;
   endtask : acc
   // flag clear as software must do it: read first, then write
   task automatic clr(input logic [1:0] a, input logic [7:0] d);
      acc(1'b0, a, 8'h00);
      acc(1'b1, a, d);
   endtask : clr
endmodule : tcs_cpu_model
`default_nettype wire

/* File: tcs_ctrl_test.sv */
// self-checking bench for the timer control/status block
// assumes: design, model and checker files compiled before this one
`timescale 1ns/1ps
`default_nettype none
module tcs_ctrl_test;
   localparam int NCH = 4;
   typedef struct packed { logic [1:0] a; logic [7:0] w; logic [7:0] r; } tcs_row_t;
   logic                i_clk = 1'b0;
   logic                i_rst_b = 1'b0;
   logic [1:0]          addr, pin = 2'h0, cstb;
   logic                rd, wr, gate = 1'b0, ext = 1'b0, start, o;
   logic [7:0]          wdata, rdata;
   logic [NCH-1:0]      tick = '0, ena = '1, enb = '1, eno = '1, tout, toen, ia, ib, io;
   logic [NCH-1:0][7:0] cnt = '0, cra = {4{8'h10}}, crb = {4{8'h20}};
   logic [1:0][7:0]     cval;
   int                  mismatches = 0;
   int                  n_checks = 0;
   // register rows: channel, written byte, byte read back
   tcs_row_t rows [4] = '{'{2'h0, 8'hFA, 8'h1A}, '{2'h1, 8'hE5, 8'h05}, '{2'h2, 8'hEF, 8'h0F}, '{2'h3, 8'hF0, 8'h10}};
   tcs_cpu_model i_cpu (.i_clk(i_clk), .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));
   tcs_ctrl #(.NCH(NCH)) i_dut (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_wdata(wdata), .o_rdata(rdata),
      .i_count_tick(tick), .i_counter8(cnt), .i_compare_reg_a(cra), .i_compare_reg_b(crb),
      .i_compare_a_irq_en(ena), .i_compare_b_irq_en(enb), .i_overflow_irq_en(eno), .i_timer_io_pin(pin),
      .i_converter_trigger_gate(gate), .i_converter_ext_trigger_pin(ext), .o_converter_start(start),
      .o_capture_strobe(cstb), .o_capture_value(cval), .o_timer_out_pin(tout), .o_timer_out_en(toen),
      .o_compare_a_irq(ia), .o_compare_b_irq(ib), .o_overflow_irq(io));
   // 125 MHz clock
   always #4 i_clk = ~i_clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one counter step of channel c from value v
   task automatic ev(input int c, input logic [7:0] v);
      cnt[c]  = v;
      tick[c] = 1'b1;
      @(posedge i_clk);
      #1;
      tick[c] = 1'b0;
   endtask : ev
   task automatic rdc(input logic [1:0] c, input logic [7:0] e);
      i_cpu.acc(1'b0, c, 8'h00);
      chk(rdata, e);
   endtask : rdc
   task automatic results;
      if (mismatches == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results
   // watchdog: the sequence needs a few hundred cycles at most
   initial begin
      #50000;
      mismatches++;
      results();
   end
   initial begin
      repeat (6) @(posedge i_clk);
      #1;
      i_rst_b = 1'b1;
      for (int c = 0; c < 4; c++) rdc(c[1:0], (c == 2) ? 8'h10 : 8'h00);
      for (int i = 0; i < 4; i++) begin
         i_cpu.acc(1'b1, rows[i].a, rows[i].w);
         rdc(rows[i].a, rows[i].r);
      end
      for (int c = 0; c < 4; c++) i_cpu.acc(1'b1, c[1:0], 8'h00);
      ev(0, 8'h10);
      chk(ia[0], 1'b1);
      eno[2] = 1'b0;
      ev(2, 8'hFF);
      chk(io[2], 1'b0);
      eno[2] = 1'b1;
      @(posedge i_clk);
      #1;
      chk(io[2], 1'b1);
      i_cpu.acc(1'b1, 2'h2, 8'h00);
      chk(io[2], 1'b1);
      i_cpu.clr(2'h2, 8'h00);
      chk(rdata, 8'h20);
      chk(io[2], 1'b0);
      rdc(2'h0, 8'h40);
      fork
         i_cpu.acc(1'b1, 2'h0, 8'h00);
         ev(0, 8'h10);
      join
      chk(ia[0], 1'b1);
      i_cpu.clr(2'h0, 8'h00);
      chk(ia[0], 1'b0);
      // channel 1 captures on rising edges; channel 0 loses its b match
      i_cpu.acc(1'b1, 2'h1, 8'h13);
      chk(toen[1], 1'b0);
      ev(0, 8'h20);
      chk(ib[0], 1'b0);
      ev(0, 8'h10);
      chk(ia[0], 1'b1);
      cnt[1] = 8'h5A;
      pin[0] = 1'b1;
      for (int k = 0; k < 4 && cstb[0] !== 1'b1; k++) begin
         @(posedge i_clk);
         #1;
      end
      chk(cstb[0], 1'b1);
      chk(cval[0], 8'h5A);
      @(posedge i_clk);
      #1;
      chk(ib[1], 1'b1);
      i_cpu.acc(1'b1, 2'h1, 8'h14);
      pin[0] = 1'b0;
      @(posedge i_clk);
      #1;
      chk(cstb[0], 1'b1);
      i_cpu.acc(1'b1, 2'h1, 8'h00);
      ev(0, 8'h20);
      chk(ib[0], 1'b1);
      i_cpu.acc(1'b1, 2'h3, 8'h10);
      ev(2, 8'h20);
      chk(ib[2], 1'b0);
      i_cpu.acc(1'b1, 2'h3, 8'h00);
      // output select: toggle on a, then one and zero on b
      i_cpu.acc(1'b1, 2'h0, 8'h03);
      chk(toen[0], 1'b1);
      o = tout[0];
      ev(0, 8'h10);
      chk(tout[0], !o);
      i_cpu.acc(1'b1, 2'h0, 8'h08);
      ev(0, 8'h20);
      chk(tout[0], 1'b1);
      i_cpu.acc(1'b1, 2'h0, 8'h04);
      ev(0, 8'h20);
      chk(tout[0], 1'b0);
      i_cpu.acc(1'b1, 2'h0, 8'h00);
      chk(toen[0], 1'b0);
      // converter start for every gate and enable pairing
      ext = 1'b1;
      for (int g = 0; g < 2; g++) begin
         for (int t = 0; t < 2; t++) begin
            i_cpu.acc(1'b1, 2'h0, {3'h0, t[0], 4'h0});
            gate = g[0];
            #1;
            chk(start, g[0] & ~t[0]);
            ext     = 1'b0;
            cnt[0]  = 8'h10;
            tick[0] = 1'b1;
            #1;
            chk(start, g[0] & t[0]);
            tick[0] = 1'b0;
            ext     = 1'b1;
         end
      end
      // second reset in mid-run
      i_rst_b = 1'b0;
      @(posedge i_clk);
      #1;
      i_rst_b = 1'b1;
      rdc(2'h2, 8'h10);
      results();
   end
endmodule : tcs_ctrl_test
bind tcs_ctrl tcs_ctrl_sva #(.NCH(NCH)) i_sva (
   .i_clk(i_clk), .i_rst_b(i_rst_b), .i_wr(i_wr), .i_count_tick(i_count_tick), .i_counter8(i_counter8),
   .i_compare_reg_a(i_compare_reg_a), .i_compare_a_irq_en(i_compare_a_irq_en),
   .i_compare_b_irq_en(i_compare_b_irq_en), .i_overflow_irq_en(i_overflow_irq_en),
   .i_converter_trigger_gate(i_converter_trigger_gate), .o_converter_start(o_converter_start),
   .o_capture_strobe(o_capture_strobe), .o_capture_value(o_capture_value), .o_compare_a_irq(o_compare_a_irq),
   .o_compare_b_irq(o_compare_b_irq), .o_overflow_irq(o_overflow_irq), .o_rdata(o_rdata));
`default_nettype wire
